// *** logic/dtid_pkg.sv ***
// shared constants and types for the debug tap instruction decoder
package dtid_pkg;
  localparam int IR_W = 8;
  localparam int ID_W = 32;
  localparam int STAT_W = 8;
  localparam int CMD_W = 6;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 32;
  localparam int BSC_W = 16;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_FAIL_BIT = 2;
  localparam logic [IR_W-1:0] OP_PIN_TEST = 8'h00;
  localparam logic [IR_W-1:0] OP_IDCODE = 8'h01;
  localparam logic [IR_W-1:0] OP_UNLOCK = 8'h02;
  localparam logic [IR_W-1:0] OP_IMPL = 8'h03;
  localparam logic [IR_W-1:0] OP_FLADDR = 8'h04;
  localparam logic [IR_W-1:0] OP_FLCMD = 8'h05;
  localparam logic [IR_W-1:0] OP_STATUS = 8'h06;
  localparam logic [IR_W-1:0] OP_SAMPLE = 8'h07;
  localparam logic [IR_W-1:0] OP_ADDR = 8'h08;
  localparam logic [IR_W-1:0] OP_DATA = 8'h09;
  localparam logic [IR_W-1:0] OP_CTRL = 8'h0A;
  localparam logic [IR_W-1:0] OP_ALL = 8'h0B;
  localparam logic [IR_W-1:0] OP_BOOTSET = 8'h0C;
  localparam logic [IR_W-1:0] OP_BOOTCLR = 8'h0D;
  localparam logic [IR_W-1:0] OP_FAST = 8'h0E;
  localparam logic [IR_W-1:0] OP_BYPASS = 8'h1F;
  localparam logic [IR_W-1:0] IR_RESET_VAL = 8'h01;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 8'h01;
  // arbitrary neutral identity value
  localparam logic [ID_W-1:0] DEVICE_ID_VAL = 32'h00001001;
  localparam logic [ID_W-1:0] IMPL_VAL = 32'h40004000;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int TCK_MIN_NS = 200;
  localparam int TCK_MIN_CYC = (TCK_MIN_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;

  typedef enum logic [3:0] {
    DTID_RESET, DTID_IDLE, DTID_SEL_DR, DTID_CAP_DR, DTID_SH_DR, DTID_EX1_DR,
    DTID_PAUSE_DR, DTID_EX2_DR, DTID_UPD_DR, DTID_SEL_IR, DTID_CAP_IR,
    DTID_SH_IR, DTID_EX1_IR, DTID_PAUSE_IR, DTID_EX2_IR, DTID_UPD_IR
  } dtid_state_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } dtid_jtag_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic fail;
  } dtid_flash_s;
endpackage

// *** logic/dtid_sync.sv ***
// three-stage pin synchroniser for the jtag inputs
`timescale 1ns/10ps
module dtid_sync
  import dtid_pkg::*;
#(
  parameter int W = 4
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // pins
  input wire logic [W-1:0] i_pin,
  // synchronised level and last stage
  output logic [W-1:0] o_lvl,
  output logic [W-1:0] o_prev
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          lvl_r[g] <= 1'b0;
        else if (s2_r[g] == s3_r[g])
          lvl_r[g] <= s3_r[g];
      end
    end
  endgenerate

  assign o_lvl = lvl_r;
  assign o_prev = s3_r;
endmodule

// *** logic/dtid_top.sv ***
// debug tap: state machine, instruction decode and data register routing
// Behaviour
// - one-hot six-bit flash command, else fail
// - status byte shifts out on tdo
// - status changes only on new command or flash done
// - status bit0 is unlock state
// - status bit1 is flash busy
// - bit2 command fail, bits 3-7 zero
// - sample/preload routes boundary chain
// - sample/preload never updates pins
// - 0x08 selects address register
// - 0x09 selects data register
// - 0x0A selects control register
// - 0x0B chains address, data, control
// - 0x0C sets debug boot flag
// - 0x0D clears debug boot flag
// - 0x0E selects data plus fast register
// - 0x1F selects one-bit bypass
// - locked port refuses privileged instructions
// - identity returns fixed 32-bit code
// - instructions are eight bits
// - locked at power-on until key match
`timescale 1ns/10ps
module dtid_top
  import dtid_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // jtag pins
  input wire dtid_jtag_s i_jtag,
  output logic o_tdo,
  output logic o_tdo_oe,
  // flash controller side
  input wire dtid_flash_s i_flash,
  input wire logic i_key_match,
  output logic [CMD_W-1:0] o_flash_cmd,
  output logic o_flash_cmd_stb,
  // boundary chain
  input wire logic [BSC_W-1:0] i_pin_sample,
  output logic [BSC_W-1:0] o_pin_drive,
  output logic o_pin_test,
  // processor debug registers
  input wire logic [CTRL_W-1:0] i_ctrl_status,
  output logic [ADDR_W-1:0] o_dbg_addr,
  output logic [DATA_W-1:0] o_dbg_data,
  output logic [CTRL_W-1:0] o_dbg_ctrl,
  output logic [DATA_W-1:0] o_fast_data,
  output logic o_boot_flag,
  output logic o_unlocked,
  output logic [IR_W-1:0] o_ir
);
  localparam int ALL_W = ADDR_W + DATA_W + CTRL_W;
  localparam int FD_W = DATA_W + 1;

  logic [3:0] lvl;
  logic tck_r;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic trst_n;

  dtid_sync #(.W(4)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin({i_jtag.tck, i_jtag.tms, i_jtag.tdi, i_jtag.trst_n}),
    .o_lvl(lvl),
    .o_prev()
  );

  assign tms = lvl[2];
  assign tdi = lvl[1];
  assign trst_n = lvl[0];

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tck_r <= 1'b0;
    else
      tck_r <= lvl[3];
  end
  assign tck_rise = lvl[3] & ~tck_r;
  assign tck_fall = ~lvl[3] & tck_r;

  dtid_state_e st_r;
  dtid_state_e st_nxt;

  // standard tap sequence, advanced on tck rise
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      DTID_RESET: st_nxt = tms ? DTID_RESET : DTID_IDLE;
      DTID_IDLE: st_nxt = tms ? DTID_SEL_DR : DTID_IDLE;
      DTID_SEL_DR: st_nxt = tms ? DTID_SEL_IR : DTID_CAP_DR;
      DTID_CAP_DR: st_nxt = tms ? DTID_EX1_DR : DTID_SH_DR;
      DTID_SH_DR: st_nxt = tms ? DTID_EX1_DR : DTID_SH_DR;
      DTID_EX1_DR: st_nxt = tms ? DTID_UPD_DR : DTID_PAUSE_DR;
      DTID_PAUSE_DR: st_nxt = tms ? DTID_EX2_DR : DTID_PAUSE_DR;
      DTID_EX2_DR: st_nxt = tms ? DTID_UPD_DR : DTID_SH_DR;
      DTID_UPD_DR: st_nxt = tms ? DTID_SEL_DR : DTID_IDLE;
      DTID_SEL_IR: st_nxt = tms ? DTID_RESET : DTID_CAP_IR;
      DTID_CAP_IR: st_nxt = tms ? DTID_EX1_IR : DTID_SH_IR;
      DTID_SH_IR: st_nxt = tms ? DTID_EX1_IR : DTID_SH_IR;
      DTID_EX1_IR: st_nxt = tms ? DTID_UPD_IR : DTID_PAUSE_IR;
      DTID_PAUSE_IR: st_nxt = tms ? DTID_EX2_IR : DTID_PAUSE_IR;
      DTID_EX2_IR: st_nxt = tms ? DTID_UPD_IR : DTID_SH_IR;
      DTID_UPD_IR: st_nxt = tms ? DTID_SEL_DR : DTID_IDLE;
      default: st_nxt = DTID_RESET;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= DTID_RESET;
    else if (!trst_n)
      st_r <= DTID_RESET;
    else if (tck_rise)
      st_r <= st_nxt;
  end

  logic adv;
  assign adv = tck_rise & trst_n;

  // lock state; key comparison lives in the flash controller
  logic unlocked_r;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      unlocked_r <= 1'b0;
    else if (i_key_match)
      unlocked_r <= 1'b1;
  end

  function automatic logic allowed(input logic [IR_W-1:0] op, input logic unl);
    logic ok;
    ok = unl;
    if (op == OP_PIN_TEST || op == OP_IDCODE || op == OP_UNLOCK || op == OP_IMPL ||
        op == OP_STATUS || op == OP_SAMPLE || op == OP_BYPASS)
      ok = 1'b1;
    return ok;
  endfunction

  // instruction register
  logic [IR_W-1:0] ir_sh_r;
  logic [IR_W-1:0] ir_r;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ir_sh_r <= '0;
      ir_r <= IR_RESET_VAL;
    end
    else if (!trst_n || (adv && st_r == DTID_RESET))
      ir_r <= IR_RESET_VAL;
    else if (adv)
    begin
      if (st_r == DTID_CAP_IR)
        ir_sh_r <= IR_CAPTURE_VAL;
      else if (st_r == DTID_SH_IR)
        ir_sh_r <= {tdi, ir_sh_r[IR_W-1:1]};
      else if (st_r == DTID_UPD_IR)
        ir_r <= allowed(ir_sh_r, unlocked_r) ? ir_sh_r : OP_BYPASS;
    end
  end

  logic upd_ir;
  assign upd_ir = adv && st_r == DTID_UPD_IR;

  // boot flag from instruction update
  logic boot_r;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      boot_r <= 1'b0;
    else if (upd_ir && allowed(ir_sh_r, unlocked_r))
    begin
      if (ir_sh_r == OP_BOOTSET)
        boot_r <= 1'b1;
      else if (ir_sh_r == OP_BOOTCLR)
        boot_r <= 1'b0;
    end
  end

  // data scan shift registers; idcode and impl share one chain, address, data, control and chained another, fast its own
  logic cap;
  logic sh;
  logic upd;
  assign cap = adv && st_r == DTID_CAP_DR;
  assign sh = adv && st_r == DTID_SH_DR;
  assign upd = adv && st_r == DTID_UPD_DR;

  logic [ID_W-1:0] id_sh_r;
  logic [STAT_W-1:0] st_sh_r;
  logic [STAT_W-1:0] stat_r;
  logic [BSC_W-1:0] bsc_sh_r;
  logic [BSC_W-1:0] bsc_upd_r;
  logic [ALL_W-1:0] all_sh_r;
  logic [FD_W-1:0] fd_sh_r;
  logic [CMD_W-1:0] cmd_sh_r;
  logic [2:0] cmd_cnt_r;
  logic byp_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [DATA_W-1:0] fast_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      id_sh_r <= '0;
      st_sh_r <= '0;
      byp_r <= 1'b0;
    end
    else if (cap)
    begin
      id_sh_r <= (ir_r == OP_IDCODE) ? DEVICE_ID_VAL : IMPL_VAL;
      st_sh_r <= stat_r;
      byp_r <= 1'b0;
    end
    else if (sh)
    begin
      id_sh_r <= {tdi, id_sh_r[ID_W-1:1]};
      st_sh_r <= {tdi, st_sh_r[STAT_W-1:1]};
      byp_r <= tdi;
    end
  end

  // command keeps the first six bits shifted; a plain chain would keep the last six
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cmd_sh_r <= '0;
      cmd_cnt_r <= '0;
    end
    else if (cap)
    begin
      cmd_sh_r <= '0;
      cmd_cnt_r <= '0;
    end
    else if (sh && cmd_cnt_r < 3'(CMD_W))
    begin
      cmd_sh_r[cmd_cnt_r] <= tdi;
      cmd_cnt_r <= cmd_cnt_r + 3'h1;
    end
  end

  // boundary chain: capture and shift for both, update only for external test
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bsc_sh_r <= '0;
      bsc_upd_r <= '0;
    end
    else if (ir_r == OP_PIN_TEST || ir_r == OP_SAMPLE)
    begin
      if (cap)
        bsc_sh_r <= i_pin_sample;
      else if (sh)
        bsc_sh_r <= {tdi, bsc_sh_r[BSC_W-1:1]};
      else if (upd && ir_r == OP_PIN_TEST)
        bsc_upd_r <= bsc_sh_r;
    end
  end

  // processor debug chains: address lsb first, then data, then control
  logic sel_a;
  logic sel_d;
  logic sel_c;
  logic sel_all;
  logic sel_f;
  assign sel_a = ir_r == OP_ADDR;
  assign sel_d = ir_r == OP_DATA;
  assign sel_c = ir_r == OP_CTRL;
  assign sel_all = ir_r == OP_ALL;
  assign sel_f = ir_r == OP_FAST;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      all_sh_r <= '0;
      fd_sh_r <= '0;
      addr_r <= '0;
      data_r <= '0;
      ctrl_r <= '0;
      fast_r <= '0;
    end
    else if (cap)
    begin
      all_sh_r <= {i_ctrl_status, data_r, addr_r};
      fd_sh_r <= {data_r, fast_r[0]};
    end
    else if (sh)
    begin
      if (sel_a)
        all_sh_r[ADDR_W-1:0] <= {tdi, all_sh_r[ADDR_W-1:1]};
      else if (sel_d)
        all_sh_r[ADDR_W +: DATA_W] <= {tdi, all_sh_r[ADDR_W+1 +: DATA_W-1]};
      else if (sel_c)
        all_sh_r[ALL_W-1 -: CTRL_W] <= {tdi, all_sh_r[ALL_W-1 -: CTRL_W-1]};
      else
        all_sh_r <= {tdi, all_sh_r[ALL_W-1:1]};
      fd_sh_r <= {tdi, fd_sh_r[FD_W-1:1]};
    end
    else if (upd)
    begin
      if (sel_a || sel_all)
        addr_r <= all_sh_r[ADDR_W-1:0];
      if (sel_d || sel_all)
        data_r <= all_sh_r[ADDR_W +: DATA_W];
      if (sel_c || sel_all)
        ctrl_r <= all_sh_r[ALL_W-1 -: CTRL_W];
      if (sel_f)
      begin
        data_r <= fd_sh_r[FD_W-1:1];
        fast_r <= {{(DATA_W-1){1'b0}}, fd_sh_r[0]};
      end
    end
  end

  // flash command issue; bits shifted past the sixth are ignored
  logic cmd_ok;
  logic cmd_stb_r;
  assign cmd_ok = $onehot(cmd_sh_r);
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cmd_stb_r <= 1'b0;
    else
      cmd_stb_r <= upd && ir_r == OP_FLCMD && cmd_ok;
  end

  // status byte is a snapshot refreshed on a new command; flash done clears busy and updates fail
  logic cmd_new;
  assign cmd_new = upd && ir_r == OP_FLCMD;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      stat_r <= '0;
    else if (cmd_new)
    begin
      stat_r <= '0;
      stat_r[STAT_LOCK_BIT] <= unlocked_r;
      stat_r[STAT_BUSY_BIT] <= cmd_ok | i_flash.busy;
      stat_r[STAT_FAIL_BIT] <= ~cmd_ok | i_flash.fail;
    end
    else if (i_flash.done)
    begin
      stat_r[STAT_BUSY_BIT] <= 1'b0;
      stat_r[STAT_FAIL_BIT] <= i_flash.fail;
    end
  end

  // tdo mux, changes on tck fall; unlisted codes fall to bypass
  logic tdo_r;
  logic oe_r;
  logic tdo_nxt;
  always_comb
  begin
    if (ir_r == OP_IDCODE || ir_r == OP_IMPL)
      tdo_nxt = id_sh_r[0];
    else if (ir_r == OP_STATUS)
      tdo_nxt = st_sh_r[0];
    else if (ir_r == OP_PIN_TEST || ir_r == OP_SAMPLE)
      tdo_nxt = bsc_sh_r[0];
    else if (sel_a || sel_all)
      tdo_nxt = all_sh_r[0];
    else if (sel_d)
      tdo_nxt = all_sh_r[ADDR_W];
    else if (sel_c)
      tdo_nxt = all_sh_r[ADDR_W + DATA_W];
    else if (sel_f)
      tdo_nxt = fd_sh_r[0];
    else
      tdo_nxt = byp_r;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tdo_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else if (tck_fall)
    begin
      oe_r <= st_r == DTID_SH_DR || st_r == DTID_SH_IR;
      tdo_r <= (st_r == DTID_SH_IR) ? ir_sh_r[0] : tdo_nxt;
    end
  end

  assign o_tdo = tdo_r;
  assign o_tdo_oe = oe_r;
  assign o_flash_cmd = cmd_sh_r;
  assign o_flash_cmd_stb = cmd_stb_r;
  assign o_pin_drive = bsc_upd_r;
  assign o_pin_test = ir_r == OP_PIN_TEST;
  assign o_dbg_addr = addr_r;
  assign o_dbg_data = data_r;
  assign o_dbg_ctrl = ctrl_r;
  assign o_fast_data = fast_r;
  assign o_boot_flag = boot_r;
  assign o_unlocked = unlocked_r;
  assign o_ir = ir_r;

  bad_cmd_fails_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_new && !cmd_ok) |=> stat_r[STAT_FAIL_BIT] && !cmd_stb_r)
    else $error("bad command not failed");
  status_upper_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    stat_r[STAT_W-1:3] == 5'h00)
    else $error("status upper bits set");
  status_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!cmd_new && !i_flash.done) |=> $stable(stat_r))
    else $error("status changed without command");
  lock_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cmd_new |=> stat_r[STAT_LOCK_BIT] == $past(unlocked_r))
    else $error("lock bit wrong");
  sample_no_update_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ir_r == OP_SAMPLE) |=> $stable(bsc_upd_r))
    else $error("sample updated pins");
  locked_refuse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (upd_ir && !unlocked_r && ir_sh_r == OP_ADDR) |=> ir_r == OP_BYPASS)
    else $error("locked accepted address");
  boot_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (upd_ir && unlocked_r && ir_sh_r == OP_BOOTSET) |=> boot_r)
    else $error("boot flag not set");
  boot_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (upd_ir && unlocked_r && ir_sh_r == OP_BOOTCLR) |=> !boot_r)
    else $error("boot flag not cleared");
  id_capture_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cap && ir_r == OP_IDCODE) |=> id_sh_r == DEVICE_ID_VAL)
    else $error("identity capture wrong");
  tap_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (adv && st_r == DTID_SEL_IR && tms) |=> st_r == DTID_RESET)
    else $error("tap sequence wrong");
endmodule

// *** test/dtid_host.sv ***
// behavioural debug host probe driving the tap pins
`timescale 1ns/10ps
module dtid_host
  import dtid_pkg::*;
(
  // clock
  input wire logic i_clk,
  // tap pins
  input wire logic i_tdo,
  output dtid_jtag_s o_jtag
);
  initial
  begin
    o_jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
  end

  // one tck period of 8 clk; tdo is read late in the high phase, well clear of its update
  task automatic tick(input logic tms_v, input logic tdi_v, output logic tdo_v);
    o_jtag.tms = tms_v;
    o_jtag.tdi = tdi_v;
    repeat (4) @(negedge i_clk);
    o_jtag.tck = 1'b1;
    repeat (4) @(negedge i_clk);
    tdo_v = i_tdo;
    o_jtag.tck = 1'b0;
  endtask

  // idle to idle scan, lsb first; tdi toggles outside the shift so stale bits never look valid
  task automatic scan(input logic is_ir, input logic [95:0] din, input int n,
                      output logic [95:0] dout);
    logic t;
    dout = '0;
    tick(1'b1, ~o_jtag.tdi, t);
    if (is_ir)
    begin
      tick(1'b1, ~o_jtag.tdi, t);
    end
    tick(1'b0, ~o_jtag.tdi, t);
    tick(1'b0, ~o_jtag.tdi, t);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], dout[i]);
    end
    tick(1'b1, ~o_jtag.tdi, t);
    tick(1'b0, ~o_jtag.tdi, t);
    // the update edge reaches the tap only after the pin synchroniser
    repeat (8) @(negedge i_clk);
  endtask

  task automatic reset_tap();
    logic t;
    repeat (5) tick(1'b1, ~o_jtag.tdi, t);
    tick(1'b0, ~o_jtag.tdi, t);
  endtask

  task automatic pulse_trst();
    o_jtag.trst_n = 1'b0;
    repeat (8) @(negedge i_clk);
    o_jtag.trst_n = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
endmodule

// *** test/dtid_top_tb.sv ***
// self-checking bench for the debug tap decoder
`timescale 1ns/10ps
module dtid_top_tb
  import dtid_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n;
  dtid_jtag_s jtag;
  dtid_flash_s flash;
  logic key;
  logic tdo;
  logic tdo_oe;
  logic [CMD_W-1:0] cmd;
  logic stb;
  logic [BSC_W-1:0] pin_sample;
  logic [BSC_W-1:0] pin_drive;
  logic pin_test;
  logic [CTRL_W-1:0] ctrl_status;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic [CTRL_W-1:0] ctrl;
  logic [DATA_W-1:0] fast;
  logic boot;
  logic unlocked;
  logic [IR_W-1:0] ir;
  logic [95:0] d;
  logic [IR_W-1:0] e;
  int n_errors = 0;
  int checks = 0;
  int n_stb = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  dtid_top i_dtid_top (.i_clk(clk), .i_rst_n(rst_n), .i_jtag(jtag), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .i_flash(flash), .i_key_match(key), .o_flash_cmd(cmd),
    .o_flash_cmd_stb(stb), .i_pin_sample(pin_sample), .o_pin_drive(pin_drive),
    .o_pin_test(pin_test), .i_ctrl_status(ctrl_status), .o_dbg_addr(addr), .o_dbg_data(data),
    .o_dbg_ctrl(ctrl), .o_fast_data(fast), .o_boot_flag(boot), .o_unlocked(unlocked),
    .o_ir(ir));

  dtid_host i_dtid_host (.i_clk(clk), .i_tdo(tdo), .o_jtag(jtag));

  task automatic final_report();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic load_ir(input logic [IR_W-1:0] code);
    logic [95:0] c;
    i_dtid_host.scan(1'b1, {88'h0, code}, IR_W, c);
    check("ir capture", c[7:0], IR_CAPTURE_VAL);
  endtask

  task automatic status_is(input logic [STAT_W-1:0] exp);
    load_ir(OP_STATUS);
    i_dtid_host.scan(1'b0, 96'h0, STAT_W, d);
    check("status", d[7:0], exp);
  endtask

  always @(posedge clk)
  begin
    n_stb += stb;
    cycles++;
    // ceiling sits well above the longest expected run
    if (cycles == 60000)
    begin
      n_errors++;
      final_report();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    flash = '0;
    key = 1'b0;
    pin_sample = 16'hA55A;
    ctrl_status = 32'hC0DE1234;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check("ir reset", ir, OP_IDCODE);
    check("unlocked", unlocked, 1'b0);
    i_dtid_host.reset_tap();
    i_dtid_host.scan(1'b0, 96'h0, ID_W, d);
    check("id", d[31:0], DEVICE_ID_VAL);
    check("oe idle", tdo_oe, 1'b0);
    status_is(8'h00);
    for (int p = 0; p < 2; p++)
    begin
      for (int c = 0; c < 32; c++)
      begin
        e = (p == 0 && !(c inside {0, 1, 2, 3, 6, 7, 31})) ? OP_BYPASS : c[7:0];
        load_ir(c[7:0]);
        if (c > 14 && c < 31)
        begin
          i_dtid_host.scan(1'b0, 96'h3, 2, d);
          check("reserved bypass", d[1:0], 2'h2);
        end
        else
        begin
          check("ir", ir, e);
        end
      end
      check("locked boot", boot, 1'b0);
      key = 1'b1;
      @(negedge clk);
      key = 1'b0;
      repeat (4) @(negedge clk);
      check("unlocked", unlocked, 1'b1);
    end
    i_dtid_host.scan(1'b0, 96'h1, 2, d);
    check("bypass", d[1:0], 2'h2);
    status_is(8'h00);
    flash.busy = 1'b1;
    load_ir(OP_FLCMD);
    i_dtid_host.scan(1'b0, 96'h4, CMD_W, d);
    check("cmd", cmd, 6'h04);
    check("stb", n_stb, 1);
    status_is(8'h03);
    flash.busy = 1'b0;
    status_is(8'h03);
    flash.done = 1'b1;
    @(negedge clk);
    flash.done = 1'b0;
    status_is(8'h01);
    load_ir(OP_FLCMD);
    i_dtid_host.scan(1'b0, 96'h3, CMD_W, d);
    check("stb", n_stb, 1);
    status_is(8'h05);
    load_ir(OP_FLCMD);
    i_dtid_host.scan(1'b0, 96'hC1, 8, d);
    check("cmd upper", cmd, 6'h01);
    check("stb", n_stb, 2);
    status_is(8'h03);
    load_ir(OP_ADDR);
    i_dtid_host.scan(1'b0, 96'h12345678, ADDR_W, d);
    check("addr", addr, 32'h12345678);
    load_ir(OP_DATA);
    i_dtid_host.scan(1'b0, 96'h9ABCDEF0, DATA_W, d);
    check("data", data, 32'h9ABCDEF0);
    load_ir(OP_CTRL);
    i_dtid_host.scan(1'b0, 96'h0F0F0F0F, CTRL_W, d);
    check("ctrl capture", d[31:0], ctrl_status);
    check("ctrl", ctrl, 32'h0F0F0F0F);
    load_ir(OP_ALL);
    i_dtid_host.scan(1'b0, 96'h33333333_22222222_11111111, 96, d);
    check("all capture", d[95:64], ctrl_status);
    check("all", {ctrl, data, addr}, 96'h33333333_22222222_11111111);
    load_ir(OP_FAST);
    i_dtid_host.scan(1'b0, {63'h0, 32'hCAFEF00D, 1'b1}, 33, d);
    check("fast data", data, 32'hCAFEF00D);
    check("fast bit", fast, 32'h00000001);
    load_ir(OP_BOOTSET);
    check("boot set", boot, 1'b1);
    load_ir(OP_BOOTCLR);
    check("boot clear", boot, 1'b0);
    load_ir(OP_SAMPLE);
    i_dtid_host.scan(1'b0, 96'h0F0F, BSC_W, d);
    check("sample", d[15:0], 16'hA55A);
    check("no update", pin_drive, 16'h0000);
    load_ir(OP_PIN_TEST);
    check("pin test", pin_test, 1'b1);
    i_dtid_host.scan(1'b0, 96'h1234, BSC_W, d);
    check("pin drive", pin_drive, 16'h1234);
    i_dtid_host.pulse_trst();
    check("ir trst", ir, OP_IDCODE);
    final_report();
  end
endmodule
